// ---- hw/mtr_pkg.sv ----
// How it works
// - one record per SA, same index
// - ingress 20 words, egress 24 words
// - operation from flow action plus record
// - normal numbering word order with padding
// - extended numbering word order with salt
// - ingress mask bounds accepted packet numbers
// - context size selects words fetched on egress; ingress always fetches 20
// - bypass and drop flows latch record word 0 but never fetch records
// - only sequence field is written back
// - word 0 bits 3:0 give direction
// - bits 19:17 select AES key length
// - egress inserts association number bits 27:26
// - 32-bit sequence, mask is replay window
// - egress sequence increments, rollover is error
// - packet below window fails, error e10
// - key words are little-endian byte groups
package mtr_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int unsigned MTR_NUM_SA = 4;
  localparam int unsigned MTR_SA_W = 2;
  localparam int unsigned MTR_MEM_DEPTH = 128;
  localparam logic [4:0] MTR_IGR_WORDS = 5'h14;
  localparam logic [4:0] MTR_EGR_WORDS = 5'h18;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [11:0] MTR_ADDR_CTRL = 12'h400;
  localparam logic [11:0] MTR_ADDR_STAT = 12'h404;
  localparam logic [1:0] MTR_CTRL_RST = 2'h0;
  localparam int unsigned MTR_CTRL_CTX_SIZE = 0;
  localparam int unsigned MTR_CTRL_XPN = 1;
  localparam int unsigned MTR_STAT_SEQ_ERR = 0;
  localparam int unsigned MTR_STAT_REPLAY = 1;
  localparam int unsigned MTR_STAT_TYPE_ERR = 2;
  localparam int unsigned MTR_STAT_BUSY = 3;

  // ****************************************************************
  // context control word
  // ****************************************************************
  localparam logic [3:0] MTR_PT_EGR = 4'h6;
  localparam logic [3:0] MTR_PT_IGR = 4'hf;
  localparam logic [2:0] MTR_CA_AES128 = 3'h5;
  localparam logic [2:0] MTR_CA_AES256 = 3'h7;
  localparam int unsigned MTR_CA_LSB = 17;
  localparam int unsigned MTR_AN_LSB = 26;
  localparam int unsigned MTR_UPD_SEQ_BIT = 13;

  // ****************************************************************
  // record word indices
  // ****************************************************************
  localparam logic [4:0] MTR_IDX_CTRL = 5'h00;
  localparam logic [4:0] MTR_IDX_KEY0 = 5'h02;
  localparam logic [4:0] MTR_KEY_WORDS_128 = 5'h04;
  localparam logic [4:0] MTR_KEY_WORDS_256 = 5'h08;
  localparam logic [4:0] MTR_HKEY_WORDS = 5'h04;
  localparam logic [31:0] MTR_SEQ_MAX = 32'hffffffff;

  typedef enum logic [1:0] {
    MTR_ACT_BYPASS,
    MTR_ACT_DROP,
    MTR_ACT_MACSEC
  } mtr_action_type;

endpackage

// ---- hw/mtr_ctrl_decode.sv ----
`timescale 1ns/1ns
module mtr_ctrl_decode import mtr_pkg::*; (
  input wire logic [31:0] ctrl_word,
  input wire logic xpn,
  output logic is_egress,
  output logic is_ingress,
  output logic type_ok,
  output logic cipher_ok,
  output logic key256,
  output logic upd_seq,
  output logic [1:0] an,
  output logic [4:0] key_last,
  output logic [4:0] seq_idx,
  output logic [4:0] mask_idx
);

  // ****************************************************************
  // field decode
  // ****************************************************************
  // reserved bits 4, 12:8 and 20 are never looked at
  wire [2:0] cipher = ctrl_word[MTR_CA_LSB +: 3];
  wire [4:0] key_words = key256 ? MTR_KEY_WORDS_256 : MTR_KEY_WORDS_128;

  assign is_egress = ctrl_word[3:0] == MTR_PT_EGR;
  assign is_ingress = ctrl_word[3:0] == MTR_PT_IGR;
  assign type_ok = is_egress | is_ingress;
  assign key256 = cipher == MTR_CA_AES256;
  assign cipher_ok = (cipher == MTR_CA_AES128) | key256;
  assign upd_seq = ctrl_word[MTR_UPD_SEQ_BIT];
  assign an = ctrl_word[MTR_AN_LSB +: 2];

  // ****************************************************************
  // layout
  // ****************************************************************
  // key and hash-key words share one byte order, so one span covers both
  assign key_last = MTR_IDX_KEY0 + key_words + MTR_HKEY_WORDS - 5'h01;
  assign seq_idx = MTR_IDX_KEY0 + key_words + MTR_HKEY_WORDS;
  // extended numbering puts the high sequence word before the mask
  assign mask_idx = xpn ? seq_idx + 5'h02 : seq_idx + 5'h01;

endmodule // mtr_ctrl_decode

// ---- hw/mtr_record_store.sv ----
`timescale 1ns/1ns
module mtr_record_store import mtr_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_start,
  input wire logic [1:0] op_sa,
  input wire mtr_action_type op_action,
  input wire logic [31:0] op_pn,
  output logic op_busy,
  output logic op_done,
  output logic op_error,
  output logic op_seq_err,
  output logic op_replay_err,
  output logic fetch_valid,
  output logic [4:0] fetch_index,
  output logic [31:0] fetch_data,
  output logic [31:0] egress_pn,
  output logic [1:0] assoc_num,
  output logic key_256,
  output logic is_egress
);

  typedef enum logic [1:0] {ST_IDLE, ST_DEC, ST_FETCH, ST_SEQ} mtr_state_type;

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [31:0] mem_r [MTR_MEM_DEPTH];
  logic [1:0] ctrl_r;
  logic [3:0] stat_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  mtr_state_type state_r;
  logic [1:0] sa_r;
  logic [31:0] pn_r;
  logic [31:0] word0_r;
  logic [4:0] cnt_r;
  logic [4:0] len_r;
  logic done_r, err_r, seq_err_r, replay_r, fv_r, key256_r, egr_r;
  logic [4:0] fidx_r;
  logic [31:0] fdata_r;
  logic [31:0] epn_r;
  logic [1:0] an_r;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire aligned = paddr[1:0] == 2'h0;
  wire rec_hit = (paddr[11:9] == 3'h0) & aligned & (paddr[6:2] < MTR_EGR_WORDS);
  wire ctrl_hit = paddr == MTR_ADDR_CTRL;
  wire stat_hit = paddr == MTR_ADDR_STAT;
  wire map_ok = rec_hit | ctrl_hit | stat_hit;
  wire setup = psel & ~penable;
  wire access = psel & penable & pready_r;
  wire wr_ok = access & pwrite & ~pslverr_r;
  // record index n sits at bits 8:7, so flow n always finds record n
  wire [6:0] host_idx = paddr[8:2];
  wire host_we = wr_ok & rec_hit;
  wire ctrl_we = wr_ok & ctrl_hit;
  wire stat_we = wr_ok & stat_hit;
  wire [31:0] rd_mux = rec_hit ? mem_r[host_idx] :
                       ctrl_hit ? {30'h0, ctrl_r} :
                       stat_hit ? {28'h0, stat_r} : 32'h0;

  // ****************************************************************
  // record decode
  // ****************************************************************
  logic d_egr, d_type_ok, d_cipher_ok, d_key256, d_upd;
  logic [1:0] d_an;
  logic [4:0] d_key_last, d_seq_idx, d_mask_idx;

  mtr_ctrl_decode u_dec (
    .ctrl_word(word0_r),
    .xpn(ctrl_r[MTR_CTRL_XPN]),
    .is_egress(d_egr),
    .is_ingress(),
    .type_ok(d_type_ok),
    .cipher_ok(d_cipher_ok),
    .key256(d_key256),
    .upd_seq(d_upd),
    .an(d_an),
    .key_last(d_key_last),
    .seq_idx(d_seq_idx),
    .mask_idx(d_mask_idx)
  );

  // ingress never reads past its 20 words, whatever the size setting
  wire [4:0] ctx_len = ctrl_r[MTR_CTRL_CTX_SIZE] ? MTR_EGR_WORDS : MTR_IGR_WORDS;
  wire [4:0] len_nxt = d_egr ? ctx_len : MTR_IGR_WORDS;
  wire dec_bad = ~d_type_ok | ~d_cipher_ok;

  // ****************************************************************
  // fetch stream
  // ****************************************************************
  wire [31:0] cur_word = mem_r[{sa_r, cnt_r}];
  wire is_key = (cnt_r >= MTR_IDX_KEY0) & (cnt_r <= d_key_last);
  // byte 0 of a key word is its low byte; present it first on the stream
  wire [31:0] fdata_nxt = is_key ? {cur_word[7:0], cur_word[15:8], cur_word[23:16], cur_word[31:24]}
                                 : cur_word;
  wire fetch_last = cnt_r == len_r - 5'h01;

  // ****************************************************************
  // sequence check and update
  // ****************************************************************
  // only the low sequence word is used: 32-bit numbering
  wire [31:0] seq_cur = mem_r[{sa_r, d_seq_idx}];
  wire [31:0] win = mem_r[{sa_r, d_mask_idx}];
  wire seq_roll = seq_cur == MTR_SEQ_MAX;
  wire pn_ge = pn_r >= seq_cur;
  // widened sum avoids wrap of next_pn minus window
  wire [32:0] pn_plus_win = {1'h0, pn_r} + {1'h0, win};
  wire in_win = pn_plus_win >= {1'h0, seq_cur};
  wire replay_fail = ~egr_r & ~pn_ge & ~in_win;
  wire seq_err_nxt = egr_r & seq_roll;
  wire in_seq = state_r == ST_SEQ;
  wire seq_we = in_seq & (egr_r ? ~seq_roll : (pn_ge & d_upd));
  wire [31:0] seq_new = egr_r ? seq_cur + 32'h1 : pn_r + 32'h1;
  wire [6:0] seq_addr = {sa_r, d_seq_idx};

  // ****************************************************************
  // status
  // ****************************************************************
  wire type_ev = (state_r == ST_DEC) & dec_bad;
  wire [3:0] stat_set = {1'h0, type_ev, in_seq & replay_fail, in_seq & seq_err_nxt};
  wire [3:0] stat_clr = stat_we ? pwdata[3:0] : 4'h0;
  // a new event beats a clear in the same cycle
  wire [2:0] stat_nxt = (stat_r[2:0] & ~stat_clr[2:0]) | stat_set[2:0];
  wire busy_nxt = state_r != ST_IDLE;

  // ****************************************************************
  // flops
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < MTR_MEM_DEPTH; i++) begin
        mem_r[i] <= 32'h0;
      end
    end else if (host_we) begin
      mem_r[host_idx] <= pwdata;
    end else if (seq_we) begin
      mem_r[seq_addr] <= seq_new;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h0;
      pready_r <= 1'h0;
      pslverr_r <= 1'h0;
      ctrl_r <= MTR_CTRL_RST;
      stat_r <= 4'h0;
    end else begin
      prdata_r <= setup & ~pwrite & map_ok ? rd_mux : 32'h0;
      pready_r <= setup;
      pslverr_r <= setup & ~map_ok;
      if (ctrl_we) begin
        ctrl_r <= pwdata[1:0];
      end
      stat_r <= {busy_nxt, stat_nxt};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      sa_r <= 2'h0;
      pn_r <= 32'h0;
      word0_r <= 32'h0;
      cnt_r <= 5'h0;
      len_r <= 5'h0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (op_start) begin
            sa_r <= op_sa;
            pn_r <= op_pn;
            cnt_r <= 5'h0;
            word0_r <= mem_r[{op_sa, MTR_IDX_CTRL}];
            // only a MACsec flow goes on to decode and fetch its record
            state_r <= op_action == MTR_ACT_MACSEC ? ST_DEC : ST_IDLE;
          end
        end
        ST_DEC: begin
          len_r <= len_nxt;
          state_r <= dec_bad ? ST_IDLE : ST_FETCH;
        end
        ST_FETCH: begin
          cnt_r <= cnt_r + 5'h01;
          state_r <= fetch_last ? ST_SEQ : ST_FETCH;
        end
        ST_SEQ: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      done_r <= 1'h0;
      err_r <= 1'h0;
      seq_err_r <= 1'h0;
      replay_r <= 1'h0;
      fv_r <= 1'h0;
      fidx_r <= 5'h0;
      fdata_r <= 32'h0;
      epn_r <= 32'h0;
      an_r <= 2'h0;
      key256_r <= 1'h0;
      egr_r <= 1'h0;
    end else begin
      done_r <= ((state_r == ST_IDLE) & op_start & (op_action != MTR_ACT_MACSEC)) | type_ev | in_seq;
      err_r <= type_ev | (in_seq & (seq_err_nxt | replay_fail));
      seq_err_r <= in_seq & seq_err_nxt;
      replay_r <= in_seq & replay_fail;
      fv_r <= state_r == ST_FETCH;
      if (state_r == ST_FETCH) begin
        fidx_r <= cnt_r;
        fdata_r <= fdata_nxt;
      end
      if (state_r == ST_DEC) begin
        egr_r <= d_egr;
        key256_r <= d_key256;
        // ingress records carry no number for the tag
        an_r <= d_egr ? d_an : 2'h0;
      end
      if (in_seq & egr_r) begin
        epn_r <= seq_new;
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign op_busy = stat_r[MTR_STAT_BUSY];
  assign op_done = done_r;
  assign op_error = err_r;
  assign op_seq_err = seq_err_r;
  assign op_replay_err = replay_r;
  assign fetch_valid = fv_r;
  assign fetch_index = fidx_r;
  assign fetch_data = fdata_r;
  assign egress_pn = epn_r;
  assign assoc_num = an_r;
  assign key_256 = key256_r;
  assign is_egress = egr_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence start_macsec_s;
    (state_r == ST_IDLE) && op_start && (op_action == MTR_ACT_MACSEC);
  endsequence

  sequence start_skip_s;
    (state_r == ST_IDLE) && op_start && (op_action != MTR_ACT_MACSEC);
  endsequence

  sequence bad_record_s;
    (state_r == ST_DEC) && dec_bad;
  endsequence

  no_record_use_a: assert property (start_skip_s |=> op_done && !op_error ##1 !fetch_valid)
    else $error("bypass or drop flow touched a record");

  bad_type_a: assert property (bad_record_s |=> op_done && op_error && !fetch_valid)
    else $error("invalid record not flagged");

  igr_len_a: assert property (fetch_valid && !is_egress |-> fetch_index < MTR_IGR_WORDS)
    else $error("ingress fetch beyond record size");

  fetch_first_a: assert property (start_macsec_s ##1 !dec_bad |=> ##1 fetch_valid && fetch_index == 5'h00)
    else $error("fetch did not start at word 0");

  fetch_end_a: assert property (fetch_valid && !$past(fv_r) |-> ##[1:24] op_done)
    else $error("fetch stream too long");

  roll_hold_a: assert property (in_seq && egr_r && seq_roll |=> op_seq_err && mem_r[$past(seq_addr)] == MTR_SEQ_MAX)
    else $error("rollover not held");

  egr_inc_a: assert property (in_seq && egr_r && !seq_roll && !host_we |=>
                              mem_r[$past(seq_addr)] == $past(seq_cur) + 32'h1 && egress_pn == $past(seq_cur) + 32'h1)
    else $error("egress sequence not incremented");

  replay_a: assert property (in_seq && replay_fail && !host_we |=>
                             op_replay_err && op_error && mem_r[$past(seq_addr)] == $past(seq_cur))
    else $error("replay failure not reported");

  only_seq_a: assert property (!host_we && !seq_we |=> mem_r[$past(host_idx)] == $past(mem_r[host_idx]))
    else $error("record changed without a write");

  an_igr_a: assert property (op_done && !is_egress |-> assoc_num == 2'h0)
    else $error("association number on ingress");

  apb_zero_wait_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not single cycle");

endmodule // mtr_record_store

// ---- tb/tb.sv ----
`timescale 1ns/1ns
module tb import mtr_pkg::*;;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic op_start = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] op_pn = 32'h0;
  logic [1:0] op_sa = 2'h0;
  mtr_action_type op_action = MTR_ACT_BYPASS;
  logic [31:0] prdata, fetch_data, egress_pn, rdat, kd;
  logic pready, pslverr, op_busy, op_done, op_error, op_seq_err, op_replay_err;
  logic fetch_valid, key_256, is_egress, rerr, e_err, e_seq, e_rep, bsy;
  logic [4:0] fetch_index;
  logic [1:0] assoc_num;
  int fail_count = 0;
  int cmp_count = 0;
  int fcnt, lat;

  mtr_record_store mtr_record_store_i (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_start(op_start), .op_sa(op_sa), .op_action(op_action), .op_pn(op_pn),
    .op_busy(op_busy), .op_done(op_done), .op_error(op_error), .op_seq_err(op_seq_err),
    .op_replay_err(op_replay_err), .fetch_valid(fetch_valid), .fetch_index(fetch_index),
    .fetch_data(fetch_data), .egress_pn(egress_pn), .assoc_num(assoc_num), .key_256(key_256),
    .is_egress(is_egress));

  always #4 mclk = ~mclk;

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // entered just after a rising edge; returns one idle edge later
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    // no cycle limit here: only the watchdog may end a wait for the answer
    do begin
      @(posedge mclk);
    end while (pready !== 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(nm, rdat, exp);
  endtask

  function automatic logic [11:0] wa(input logic [1:0] s, input int w);
    wa = {3'h0, s, 7'h00} + 12'(4 * w);
  endfunction

  // control word as software must build it for a valid macsec record
  function automatic logic [31:0] ctl(input logic egr, input logic k256, input logic [1:0] an);
    ctl = 32'h0;
    ctl[31] = 1'h1;
    ctl[30] = ~egr;
    ctl[29:28] = 2'h1;
    ctl[27:26] = an;
    ctl[25:23] = 3'h4;
    ctl[22:21] = 2'h2;
    ctl[19:17] = k256 ? 3'h7 : 3'h5;
    ctl[16:13] = 4'hf;
    ctl[7:5] = 3'h3;
    ctl[3:0] = egr ? 4'h6 : 4'hf;
  endfunction

  task automatic fill(input logic [1:0] s, input logic [31:0] c, input int si, input logic [31:0] sq,
    input logic [31:0] mk);
    for (int w = 0; w < 24; w++) begin
      apb(1'h1, wa(s, w), (w == 0) ? c : (w == si) ? sq : (w == si + 1) ? mk : {24'h0a0b0c, 8'(w)});
    end
  endtask

  task automatic op(input logic [1:0] s, input mtr_action_type a, input logic [31:0] pn);
    op_sa <= s;
    op_action <= a;
    op_pn <= pn;
    op_start <= 1'h1;
    // lat names the cycle being looked at, the start cycle being 0
    lat = -1;
    fcnt = 0;
    bsy = 1'h0;
    do begin
      @(posedge mclk);
      op_start <= 1'h0;
      lat++;
      if (lat == 2) bsy = op_busy;
      if (fetch_valid === 1'h1) begin
        chk("fetch idx", fetch_index, fcnt);
        fcnt++;
        if (fetch_index === 5'h02) kd = fetch_data;
      end
    end while (op_done !== 1'h1);
    e_err = op_error;
    e_seq = op_seq_err;
    e_rep = op_replay_err;
    @(posedge mclk);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rdc("ctrl", MTR_ADDR_CTRL, 32'h0);
    rdc("stat", MTR_ADDR_STAT, 32'h0);
    rdc("rec word", wa(2'h3, 23), 32'h0);
    apb(1'h0, 12'h060, 32'h0);
    chk("unmapped err", rerr, 32'h1);
    chk("unmapped data", rdat, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_egress();
    fill(2'h1, ctl(1'h1, 1'h0, 2'h2), 10, 32'h5, 32'h0);
    op(2'h1, MTR_ACT_MACSEC, 32'h0);
    chk("lat20", lat, 23);
    chk("fetch20", fcnt, 20);
    chk("busy", bsy, 32'h1);
    chk("key order", kd, 32'h020c0b0a);
    chk("egress pn", egress_pn, 32'h6);
    chk("an", assoc_num, 32'h2);
    chk("decode", {e_err, is_egress, key_256}, 32'h2);
    rdc("seq", wa(2'h1, 10), 32'h6);
    rdc("ctx id", wa(2'h1, 1), 32'h0a0b0c01);
    apb(1'h1, MTR_ADDR_CTRL, 32'h1);
    op(2'h1, MTR_ACT_MACSEC, 32'h0);
    chk("lat24", lat, 27);
    chk("fetch24", fcnt, 24);
    chk("egress pn2", egress_pn, 32'h7);
    apb(1'h1, MTR_ADDR_CTRL, 32'h0);
    $display("test egress done");
  endtask

  task automatic t_roll();
    fill(2'h2, ctl(1'h1, 1'h1, 2'h3), 14, 32'hffffffff, 32'h0);
    op(2'h2, MTR_ACT_MACSEC, 32'h0);
    chk("roll flags", {e_err, e_seq, e_rep}, 32'h6);
    chk("key256", key_256, 32'h1);
    chk("an3", assoc_num, 32'h3);
    rdc("seq kept", wa(2'h2, 14), 32'hffffffff);
    rdc("stat seq", MTR_ADDR_STAT, 32'h1);
    apb(1'h1, MTR_ADDR_STAT, 32'h1);
    rdc("stat clr", MTR_ADDR_STAT, 32'h0);
    $display("test rollover done");
  endtask

  task automatic t_ingress();
    fill(2'h0, ctl(1'h0, 1'h0, 2'h0), 10, 32'ha, 32'h2);
    op(2'h0, MTR_ACT_MACSEC, 32'h7);
    chk("replay flags", {e_err, e_seq, e_rep}, 32'h5);
    rdc("seq kept", wa(2'h0, 10), 32'ha);
    rdc("stat rep", MTR_ADDR_STAT, 32'h2);
    apb(1'h1, MTR_ADDR_STAT, 32'h2);
    op(2'h0, MTR_ACT_MACSEC, 32'h8);
    chk("window flags", {e_err, e_seq, e_rep}, 32'h0);
    rdc("seq same", wa(2'h0, 10), 32'ha);
    op(2'h0, MTR_ACT_MACSEC, 32'hc);
    chk("ahead flags", {e_err, e_seq, e_rep}, 32'h0);
    chk("ig decode", {is_egress, assoc_num}, 32'h0);
    chk("ig fetch", fcnt, 20);
    rdc("seq adv", wa(2'h0, 10), 32'hd);
    apb(1'h1, MTR_ADDR_CTRL, 32'h2);
    apb(1'h1, wa(2'h0, 12), 32'h5);
    op(2'h0, MTR_ACT_MACSEC, 32'h9);
    chk("xpn mask", {e_err, e_rep}, 32'h0);
    apb(1'h1, MTR_ADDR_CTRL, 32'h0);
    $display("test ingress done");
  endtask

  task automatic t_misc();
    mtr_action_type acts [2];
    logic [31:0] bad [2];
    acts = '{MTR_ACT_BYPASS, MTR_ACT_DROP};
    bad = '{(ctl(1'h1, 1'h0, 2'h0) & 32'hfffffff0) | 32'h5, ctl(1'h1, 1'h0, 2'h0) ^ 32'h00080000};
    foreach (acts[i]) begin
      op(2'h1, acts[i], 32'h0);
      chk("nx lat", lat, 1);
      chk("nx fetch", fcnt, 0);
      chk("nx err", e_err, 32'h0);
    end
    foreach (bad[i]) begin
      apb(1'h1, wa(2'h3, 0), bad[i]);
      op(2'h3, MTR_ACT_MACSEC, 32'h0);
      chk("bad lat", lat, 2);
      chk("bad err", e_err, 32'h1);
      chk("bad fetch", fcnt, 0);
      chk("bad busy", bsy, 32'h1);
    end
    rdc("stat type", MTR_ADDR_STAT, 32'h4);
    apb(1'h1, MTR_ADDR_STAT, 32'h4);
    apb(1'h1, wa(2'h3, 0), ctl(1'h1, 1'h0, 2'h1) | 32'h00101f10);
    op(2'h3, MTR_ACT_MACSEC, 32'h0);
    chk("rsvd err", e_err, 32'h0);
    chk("rsvd pn", egress_pn, 32'h1);
    chk("rsvd an", assoc_num, 32'h1);
    $display("test misc done");
  endtask

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    t_reset();
    t_egress();
    t_roll();
    t_ingress();
    t_misc();
    test_done();
  end

  // whole run needs several hundred cycles; the 50000-cycle limit leaves ample margin
  initial begin
    #400000;
    fail_count++;
    $display("watchdog expired");
    test_done();
  end
endmodule // tb
